// File: logic/cgw_clock_gen.sv
// cpu clock generator: strap decode, prescaler, direct, pll, failover
`timescale 1ns/10ps
`include "cgw_consts.svh"

// How it works
// RULE1 - straps latched in reset fix the mode
// RULE2 - strap codes map to factors and modes
// RULE3 - strap 001 halves the input frequency
// RULE4 - prescaled half-period equals one input period
// RULE5 - strap 011 follows the input directly
// RULE6 - direct pair of half-periods equals input period
// RULE7 - other straps multiply input by factor
// RULE8 - pll resyncs smoothly every F transitions
// RULE9 - both cpu clock edges mark timing units
// RULE10 - watchdog only in direct or prescaled modes
// RULE11 - watchdog on after reset, disable bit
// RULE12 - free cycles count, input edges clear
// RULE13 - sixteen silent cycles switch to free-run
// RULE14 - overflow sets the clock fail flag
// RULE15 - free-run held until hardware reset
// RULE16 - disabled watchdog: input clock, pll off
// RULE17 - synchronised detection, glitch-free switchover
module cgw_clock_gen
  import cgw_pkg::*;
#(
  parameter int PERIOD_W = 16,
  parameter int FREE_HALF_CYC = `CGW_FREE_HALF_CYC
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic oscInputPin,
  input wire logic [`CGW_STRAP_W-1:0] clockModeStrapPins,
  input wire logic oscWatchdogDisable,
  input wire logic clockFailIrqClear,
  output logic cpuClk,
  output logic cpuEdge,
  output logic clockFailIrqFlag,
  output cgw_status_type status
);

  localparam logic [PERIOD_W-1:0] PERIOD_ONE = PERIOD_W'(1);
  localparam logic [PERIOD_W-1:0] PERIOD_INIT = PERIOD_W'(`CGW_PERIOD_INIT);
  localparam logic [PERIOD_W-1:0] FREE_LAST = PERIOD_W'(FREE_HALF_CYC - 1);
  localparam logic signed [PERIOD_W:0] STEP_ONE = (PERIOD_W+1)'(1);
  localparam logic signed [PERIOD_W:0] STEP_ZERO = '0;

  if (PERIOD_W < 8 || PERIOD_W > 30) begin : badPeriodWidth
    $error("cgw_clock_gen: PERIOD_W must lie in 8..30");
  end
  if (FREE_HALF_CYC < 1) begin : badFreeHalf
    $error("cgw_clock_gen: FREE_HALF_CYC must be at least 1");
  end

  logic [`CGW_STRAP_W-1:0] strap_q;
  logic started_q;
  cgw_src_type src_q;
  cgw_src_type src_d;
  logic switchPending_q;
  logic cpuClk_q;
  logic cpuClk_d;
  logic cpuEdge_q;
  logic irqFlag_q;
  logic [PERIOD_W-1:0] freeCnt_q;
  logic freeTick;
  logic pllEnable;
  logic monitorEnable;
  logic overflow;
  cgw_osc_type oscEvents;
  logic [`CGW_FX2_W-1:0] fx2;
  logic [`CGW_FX2_W-1:0] syncEvery;
  logic [PERIOD_W-1:0] measure_q;
  logic [PERIOD_W-1:0] period_q;
  logic [PERIOD_W:0] acc_q;
  logic [PERIOD_W:0] accSum;
  logic [PERIOD_W:0] accPull;
  logic signed [PERIOD_W:0] periodStep;
  logic ncoEdge;
  logic [`CGW_FX2_W-1:0] transCnt_q;
  logic resync;
  logic signed [PERIOD_W:0] periodDiff;
  logic [3:0] lockCnt_q;
  logic pllLocked;

  // strap pins are sampled on every edge while reset is held
  always_ff @(posedge clk) begin
    if (!rstn) begin
      strap_q <= clockModeStrapPins; // RULE1
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  function automatic logic [`CGW_FX2_W-1:0] factorOf(
    input logic [`CGW_STRAP_W-1:0] code
  );
    case (code)
      `CGW_STRAP_X4: factorOf = `CGW_FX2_X4; // RULE2
      `CGW_STRAP_X3: factorOf = `CGW_FX2_X3;
      `CGW_STRAP_X2: factorOf = `CGW_FX2_X2;
      `CGW_STRAP_X5: factorOf = `CGW_FX2_X5;
      `CGW_STRAP_X1P5: factorOf = `CGW_FX2_X1P5;
      `CGW_STRAP_X2P5: factorOf = `CGW_FX2_X2P5;
      default: factorOf = `CGW_FX2_X1;
    endcase
  endfunction

  function automatic cgw_src_type sourceOf(
    input logic [`CGW_STRAP_W-1:0] code
  );
    case (code)
      `CGW_STRAP_DIRECT: sourceOf = SRC_DIRECT; // RULE5
      `CGW_STRAP_PRESCALE: sourceOf = SRC_PRESCALE; // RULE3
      default: sourceOf = SRC_PLL; // RULE7
    endcase
  endfunction

  assign fx2 = factorOf(strap_q);
  // F transitions, rounded up for the half factors
  assign syncEvery = (fx2 + 1'b1) >> 1;

  // mode fixed from the straps on the first edge after release
  always_comb begin
    src_d = src_q;
    case (src_q)
      SRC_DIRECT, SRC_PRESCALE: begin
        // switch only while low and on a free tick, so no runt pulse
        if (switchPending_q && !cpuClk_q && freeTick) begin
          src_d = SRC_FREERUN; // RULE13 RULE17
        end
      end
      SRC_PLL: src_d = SRC_PLL;
      SRC_FREERUN: src_d = SRC_FREERUN; // RULE15
      default: src_d = SRC_PLL;
    endcase
    if (!started_q) begin
      src_d = sourceOf(strap_q); // RULE1
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      src_q <= SRC_PLL;
    end else begin
      src_q <= src_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      switchPending_q <= 1'b0;
    end else if (src_q == SRC_FREERUN) begin
      switchPending_q <= 1'b0;
    end else if (overflow) begin
      switchPending_q <= 1'b1;
    end
  end

  // watchdog only where the input drives the cpu directly
  assign monitorEnable = started_q && !oscWatchdogDisable &&
    (src_q == SRC_DIRECT || src_q == SRC_PRESCALE); // RULE10 RULE11

  // pll off in input-driven modes while the watchdog is disabled
  assign pllEnable = (src_q == SRC_PLL) || (src_q == SRC_FREERUN) ||
    monitorEnable || switchPending_q; // RULE16

  // free-running oscillator stand-in, stopped when pll is off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      freeCnt_q <= '0;
    end else if (!pllEnable || freeCnt_q == FREE_LAST) begin
      freeCnt_q <= '0;
    end else begin
      freeCnt_q <= freeCnt_q + PERIOD_ONE; // RULE12
    end
  end

  assign freeTick = pllEnable && (freeCnt_q == FREE_LAST);

  cgw_osc_watchdog wdog (
    .clk(clk),
    .rstn(rstn),
    .oscInputPin(oscInputPin),
    .monitorEnable(monitorEnable),
    .freeTick(freeTick),
    .oscEvents(oscEvents),
    .overflow(overflow)
  );

  // input period in clk cycles, rise to rise, saturating
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      measure_q <= '0;
    end else if (oscEvents.rise) begin
      measure_q <= PERIOD_ONE;
    end else if (measure_q != '1) begin
      measure_q <= measure_q + PERIOD_ONE;
    end
  end

  assign periodDiff = $signed({1'b0, measure_q}) -
    $signed({1'b0, period_q});

  // floor alone stalls a small positive error: add one step
  assign periodStep = (periodDiff >>> `CGW_SMOOTH_SHIFT) +
    ((periodDiff > 0) ? STEP_ONE : STEP_ZERO);

  // moves a fraction of the error per period: frequency never jumps
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      period_q <= PERIOD_INIT;
    end else if (src_q == SRC_PLL && oscEvents.rise) begin
      period_q <= PERIOD_W'($signed({1'b0, period_q}) +
        periodStep); // RULE8
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lockCnt_q <= '0;
    end else if (src_q != SRC_PLL) begin
      lockCnt_q <= '0;
    end else if (oscEvents.rise) begin
      if (periodDiff > `CGW_LOCK_TOL || periodDiff < -`CGW_LOCK_TOL) begin
        lockCnt_q <= '0;
      end else if (lockCnt_q != `CGW_LOCK_COUNT) begin
        lockCnt_q <= lockCnt_q + 4'h1;
      end
    end
  end

  assign pllLocked = (lockCnt_q == `CGW_LOCK_COUNT);

  // input transitions counted so phase is pulled every F of them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      transCnt_q <= '0;
    end else if (src_q != SRC_PLL) begin
      transCnt_q <= '0;
    end else if (oscEvents.rise || oscEvents.fall) begin
      if (transCnt_q + 1'b1 >= syncEvery) begin
        transCnt_q <= '0;
      end else begin
        transCnt_q <= transCnt_q + 1'b1;
      end
    end
  end

  assign resync = (src_q == SRC_PLL) &&
    (oscEvents.rise || oscEvents.fall) &&
    (transCnt_q + 1'b1 >= syncEvery); // RULE8

  // fractional oscillator: fx2 cpu edges per measured input period
  assign accSum = acc_q + {{(PERIOD_W+1-`CGW_FX2_W){1'b0}}, fx2};
  assign ncoEdge = (src_q == SRC_PLL) && (accSum >= {1'b0, period_q});

  // pull half-way to the nearer carry point, so phase stays bounded
  assign accPull = (accSum >= {2'b00, period_q[PERIOD_W-1:1]}) ?
    accSum + (({1'b0, period_q} - accSum) >> 1) : accSum >> 1;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_q <= '0;
    end else if (src_q != SRC_PLL) begin
      acc_q <= '0;
    end else if (ncoEdge) begin
      acc_q <= accSum - {1'b0, period_q}; // RULE7
    end else if (resync) begin
      // halve the phase error instead of snapping to the input
      acc_q <= accPull; // RULE8
    end else begin
      acc_q <= accSum;
    end
  end

  // cpu clock source per mode; a whole clk of delay in every mode
  always_comb begin
    cpuClk_d = cpuClk_q;
    case (src_q)
      SRC_DIRECT: cpuClk_d = oscEvents.level; // RULE5 RULE6
      SRC_PRESCALE: cpuClk_d = cpuClk_q ^ oscEvents.rise; // RULE3 RULE4
      SRC_PLL: cpuClk_d = cpuClk_q ^ ncoEdge; // RULE7
      SRC_FREERUN: cpuClk_d = cpuClk_q ^ freeTick; // RULE13
      default: cpuClk_d = cpuClk_q;
    endcase
    // a dead input may leave the clock high: end that phase on a tick
    if (switchPending_q && src_q != SRC_FREERUN) begin
      cpuClk_d = cpuClk_q & ~freeTick; // RULE13 RULE17
    end
    if (!started_q) begin
      cpuClk_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpuClk_q <= 1'b0;
      cpuEdge_q <= 1'b0;
    end else begin
      cpuClk_q <= cpuClk_d;
      cpuEdge_q <= cpuClk_d ^ cpuClk_q; // RULE9
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqFlag_q <= 1'b0;
    end else if (overflow) begin
      irqFlag_q <= 1'b1; // RULE14
    end else if (clockFailIrqClear) begin
      irqFlag_q <= 1'b0;
    end
  end

  assign cpuClk = cpuClk_q;
  assign cpuEdge = cpuEdge_q;
  assign clockFailIrqFlag = irqFlag_q;
  assign status.pllEnable = pllEnable;
  assign status.watchdogActive = monitorEnable;
  assign status.onFreeRun = (src_q == SRC_FREERUN);
  assign status.pllLocked = pllLocked;
  assign status.strap = strap_q;

endmodule

// File: logic/cgw_consts.svh
// constants for the cpu clock generator with oscillator watchdog
`ifndef CGW_CONSTS_SVH
`define CGW_CONSTS_SVH

`define CGW_CLK_MHZ 50
`define CGW_STRAP_W 3

`define CGW_STRAP_X4 3'h7
`define CGW_STRAP_X3 3'h6
`define CGW_STRAP_X2 3'h5
`define CGW_STRAP_X5 3'h4
`define CGW_STRAP_DIRECT 3'h3
`define CGW_STRAP_X1P5 3'h2
`define CGW_STRAP_PRESCALE 3'h1
`define CGW_STRAP_X2P5 3'h0

// factor F held as twice its value, so 1.5 and 2.5 stay whole
`define CGW_FX2_W 5
`define CGW_FX2_X4 5'h08
`define CGW_FX2_X3 5'h06
`define CGW_FX2_X2 5'h04
`define CGW_FX2_X5 5'h0A
`define CGW_FX2_X1 5'h02
`define CGW_FX2_X1P5 5'h03
`define CGW_FX2_X2P5 5'h05

`define CGW_WDOG_W 5
`define CGW_WDOG_OVF 5'h10

// free-running pll half period, in ns
`define CGW_FREE_HALF_NS 40
`define CGW_FREE_HALF_CYC ((`CGW_FREE_HALF_NS * `CGW_CLK_MHZ) / 1000)

`define CGW_SMOOTH_SHIFT 2
`define CGW_LOCK_TOL 4
`define CGW_LOCK_COUNT 4'h8
// starting estimate of the input period, in clk cycles
`define CGW_PERIOD_INIT 16

`endif

// File: logic/cgw_pkg.sv
// types shared by the clock generator files
package cgw_pkg;

  typedef enum logic [3:0] {
    SRC_DIRECT = 4'b0001,
    SRC_PRESCALE = 4'b0010,
    SRC_PLL = 4'b0100,
    SRC_FREERUN = 4'b1000
  } cgw_src_type;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } cgw_osc_type;

  typedef struct packed {
    logic pllEnable;
    logic watchdogActive;
    logic onFreeRun;
    logic pllLocked;
    logic [2:0] strap;
  } cgw_status_type;

endpackage

// File: logic/cgw_osc_watchdog.sv
// input clock loss monitor: pin synchroniser and overflow counter
`timescale 1ns/10ps
`include "cgw_consts.svh"

module cgw_osc_watchdog
  import cgw_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic oscInputPin,
  input wire logic monitorEnable,
  input wire logic freeTick,
  output cgw_osc_type oscEvents,
  output logic overflow
);

  logic syncA_q;
  logic syncB_q;
  logic syncC_q;
  logic [`CGW_WDOG_W-1:0] count_q;
  logic transition;

  // first flop feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
      syncC_q <= 1'b0;
    end else begin
      syncA_q <= oscInputPin; // RULE17
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end

  assign transition = syncB_q ^ syncC_q;
  assign oscEvents.level = syncB_q;
  assign oscEvents.rise = syncB_q & ~syncC_q;
  assign oscEvents.fall = ~syncB_q & syncC_q;

  // counts free-running cycles, any pin edge clears it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= '0;
    end else if (!monitorEnable || transition) begin
      count_q <= '0; // RULE12
    end else if (freeTick && count_q != `CGW_WDOG_OVF) begin
      count_q <= count_q + 1'b1; // RULE12
    end
  end

  // one pulse as the sixteenth cycle passes without an edge
  assign overflow = monitorEnable && !transition && freeTick &&
    (count_q == `CGW_WDOG_OVF - 1'b1); // RULE13

endmodule

// File: testbench/cgw_osc_model.sv
// oscillator source model for the input clock pin
`timescale 1ns/10ps
module cgw_osc_model (
  input wire logic clk,
  input wire logic run,
  input wire logic [7:0] hiCyc,
  input wire logic [7:0] loCyc,
  output logic oscInputPin
);
  logic [7:0] cnt = 8'h00;
  logic pinLevel = 1'b0;
  assign oscInputPin = pinLevel;
  // a dead source holds its level, so it gives no edges at all
  always @(negedge clk) begin
    if (run) begin
      cnt = cnt + 8'h01;
      if (cnt >= (pinLevel ? hiCyc : loCyc)) begin
        pinLevel <= ~pinLevel;
        cnt = 8'h00;
      end
    end
  end
endmodule

// File: testbench/cgw_clock_gen_sva.sv
// port assertions for the cpu clock generator
`timescale 1ns/10ps
`include "cgw_consts.svh"
module cgw_clock_gen_sva
  import cgw_pkg::*;
#(
  parameter int PERIOD_W = 16,
  parameter int FREE_HALF_CYC = 2
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic oscInputPin,
  input wire logic [`CGW_STRAP_W-1:0] clockModeStrapPins,
  input wire logic oscWatchdogDisable,
  input wire logic clockFailIrqClear,
  input wire logic cpuClk,
  input wire logic cpuEdge,
  input wire logic clockFailIrqFlag,
  input wire cgw_status_type status
);
  logic [2:0] upCnt_q;
  logic [2:0] md;
  logic free;
  assign md = status.strap;
  assign free = status.onFreeRun;
  // guards $past from looking back into reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      upCnt_q <= 3'h0;
    end else if (upCnt_q != 3'h7) begin
      upCnt_q <= upCnt_q + 3'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_edge_pulse: assert property (
    upCnt_q > 3'h1 |-> cpuEdge == (cpuClk != $past(cpuClk)))
    else $error("edge pulse does not match clock change");
  chk_strap_fixed: assert property (
    upCnt_q > 3'h2 |-> $stable(status.strap))
    else $error("mode changed after reset");
  chk_pll_quiet: assert property (
    upCnt_q > 3'h2 && md != `CGW_STRAP_DIRECT && md != `CGW_STRAP_PRESCALE
      |-> !status.watchdogActive && !free)
    else $error("watchdog acts in pll mode");
  chk_direct_follow: assert property (
    upCnt_q == 3'h7 && md == `CGW_STRAP_DIRECT && !free && !clockFailIrqFlag
      |-> cpuClk == $past(oscInputPin, 3))
    else $error("direct clock does not follow pin");
  chk_prescale_step: assert property (
    upCnt_q == 3'h7 && md == `CGW_STRAP_PRESCALE && !free && cpuEdge &&
      !clockFailIrqFlag
      |-> $past(oscInputPin, 3) && !$past(oscInputPin, 4))
    else $error("prescaled toggle without pin rise");
  chk_free_sticky: assert property (
    free |=> free) else $error("left free-running clock");
  chk_flag_sticky: assert property (
    clockFailIrqFlag && !clockFailIrqClear |=> clockFailIrqFlag)
    else $error("fail flag dropped");
  chk_flag_switch: assert property (
    $rose(clockFailIrqFlag) |-> ##[0:8] free)
    else $error("no switch after clock fail");
  chk_switch_low: assert property (
    $rose(free) |-> !cpuClk)
    else $error("switch to free-run with clock high");
endmodule
bind cgw_clock_gen cgw_clock_gen_sva #(.PERIOD_W(PERIOD_W),
  .FREE_HALF_CYC(FREE_HALF_CYC)) u_sva (.clk, .rstn, .oscInputPin,
  .clockModeStrapPins, .oscWatchdogDisable, .clockFailIrqClear,
  .cpuClk, .cpuEdge, .clockFailIrqFlag, .status);

// File: testbench/test_cpu_clock_gen_osc_watchdog.sv
// self-checking bench for the cpu clock generator
`timescale 1ns/10ps
`include "cgw_consts.svh"
module test_cpu_clock_gen_osc_watchdog
  import cgw_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] clockModeStrapPins = 3'h7;
  logic oscWatchdogDisable = 1'b0;
  logic clockFailIrqClear = 1'b0;
  logic run = 1'b1;
  logic [7:0] hiCyc = 8'h03;
  logic [7:0] loCyc = 8'h05;
  logic oscInputPin;
  logic cpuClk;
  logic cpuEdge;
  logic clockFailIrqFlag;
  cgw_status_type status;
  int errors = 0;
  int checks_done = 0;
  logic [7:0] a;
  logic [7:0] b;
  always #10 clk = ~clk;
  cgw_osc_model u_osc (.clk, .run, .hiCyc, .loCyc, .oscInputPin);
  cgw_clock_gen #(.PERIOD_W(16), .FREE_HALF_CYC(2)) u_dut (.clk, .rstn,
    .oscInputPin, .clockModeStrapPins, .oscWatchdogDisable,
    .clockFailIrqClear, .cpuClk, .cpuEdge, .clockFailIrqFlag, .status);
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic in_range(input logic [7:0] got, lo, hi);
    checks_done++;
    if (!(got >= lo && got <= hi)) begin
      errors++;
      $display("Error at %0t: got %0h limits %0h %0h", $time, got, lo, hi);
    end
  endtask
  task automatic start(input logic [2:0] s, input logic d);
    @(negedge clk);
    rstn = 1'b0;
    clockModeStrapPins = s;
    oscWatchdogDisable = d;
    run = 1'b1;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    // straps move after reset; the mode must not
    clockModeStrapPins = ~s;
    repeat (8) @(negedge clk);
    check(8'(status.strap), 8'(s));
  endtask
  task automatic half(output logic [7:0] n);
    int k;
    n = 8'h00;
    for (k = 0; k < 99 && cpuEdge !== 1'b1; k++) @(negedge clk);
    for (k = 0; k < 99; k++) begin
      @(negedge clk);
      n = n + 8'h01;
      if (cpuEdge === 1'b1) break;
    end
  endtask
  task automatic t_prescale();
    start(`CGW_STRAP_PRESCALE, 1'b0);
    check(8'(status.watchdogActive), 8'h01);
    check(8'(status.pllEnable), 8'h01);
    half(a);
    repeat (3) begin
      half(a);
      check(a, 8'h08);
    end
  endtask
  task automatic t_direct();
    start(`CGW_STRAP_DIRECT, 1'b0);
    half(a);
    half(a);
    half(b);
    check(a + b, 8'h08);
    check(a * b, 8'h0F);
  endtask
  task automatic t_fail();
    int k;
    start(`CGW_STRAP_DIRECT, 1'b0);
    @(oscInputPin);
    @(negedge clk);
    run = 1'b0;
    for (k = 0; k < 99 && clockFailIrqFlag !== 1'b1; k++) @(negedge clk);
    // 16 ticks of 2 clk plus synchroniser delay
    in_range(8'(k), 8'h1E, 8'h28);
    for (k = 0; k < 99 && status.onFreeRun !== 1'b1; k++) @(negedge clk);
    in_range(8'(k), 8'h00, 8'h08);
    run = 1'b1;
    repeat (50) @(negedge clk);
    check(8'(status.onFreeRun), 8'h01);
    half(a);
    half(a);
    check(a, 8'h02);
    clockFailIrqClear = 1'b1;
    @(negedge clk);
    clockFailIrqClear = 1'b0;
    @(negedge clk);
    check(8'(clockFailIrqFlag), 8'h00);
    start(`CGW_STRAP_DIRECT, 1'b0);
    check(8'(status.onFreeRun), 8'h00);
  endtask
  task automatic t_off();
    start(`CGW_STRAP_PRESCALE, 1'b1);
    check(8'(status.pllEnable), 8'h00);
    check(8'(status.watchdogActive), 8'h00);
    run = 1'b0;
    repeat (100) @(negedge clk);
    check(8'({clockFailIrqFlag, status.onFreeRun}), 8'h00);
  endtask
  task automatic t_pll();
    logic [2:0] s [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h0};
    logic [7:0] f [6] = '{8'h08, 8'h06, 8'h04, 8'h0A, 8'h03, 8'h05};
    hiCyc = 8'h14;
    loCyc = 8'h14;
    foreach (s[i]) begin
      start(s[i], 1'b0);
      check(8'(status.watchdogActive), 8'h00);
      repeat (800) @(negedge clk);
      a = 8'h00;
      repeat (400) begin
        @(negedge clk);
        a = a + 8'(cpuEdge);
      end
      // doubled factor is edges per input period; resync steps blur it
      in_range(a, f[i] * 8'h0A - 8'h03, f[i] * 8'h0A + 8'h03);
      check(8'(status.pllLocked), 8'h01);
      run = 1'b0;
      repeat (100) @(negedge clk);
      check(8'(clockFailIrqFlag), 8'h00);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    t_prescale();
    t_direct();
    t_fail();
    t_off();
    t_pll();
    results();
  end
  // tests take about 8200 cycles; allow over twice that
  initial begin
    #400000;
    errors++;
    results();
  end
endmodule
